// [shared/asrc_pkg.sv]
// asrc_pkg: constants for the asynchronous sram host controller
// assumes a 100 MHz ref_clk; memory pins are driven straight from flops
//
// Behaviour
// - write happens only while both selects active and strobe low.
// - host holds both selects active a grade minimum before write end.
// - host write pulse meets grade minimum, longer with output gate low.
// - host drives data only after memory outputs have gone high impedance.
// - host sets address no later than the later select activation.
// - host holds write data valid a grade minimum before write end.
// - host holds address a grade minimum before write end, zero setup.
// - host keeps zero recovery and each write cycle a grade minimum long.
`default_nettype none

package asrc_pkg;
  localparam int ASRC_ADDR_W  = 17;
  localparam int ASRC_DATA_W  = 8;
  localparam int ASRC_CLK_PS  = 10000;  // ref_clk period in ps
  // speed grade index: 0 fast, 1 middle, 2 slow
  localparam int ASRC_GRADE_FAST = 0;
  localparam int ASRC_GRADE_MID  = 1;
  localparam int ASRC_GRADE_SLOW = 2;

  // least times in ns per grade
  function automatic int asrc_pick(input int g, input int a, input int b,
                                   input int c);
    asrc_pick = (g == ASRC_GRADE_FAST) ? a : (g == ASRC_GRADE_MID) ? b : c;
  endfunction : asrc_pick

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int asrc_cyc(input int ns);
    int c;
    c = (ns * 1000 + ASRC_CLK_PS - 1) / ASRC_CLK_PS;
    asrc_cyc = (c < 1) ? 1 : c;
  endfunction : asrc_cyc

  function automatic int asrc_rc_ns(input int g);   // read/write cycle, access
    asrc_rc_ns = asrc_pick(g, 12, 15, 20);
  endfunction : asrc_rc_ns
  function automatic int asrc_wp_ns(input int g);   // write pulse, gate high
    asrc_wp_ns = asrc_pick(g, 8, 12, 15);
  endfunction : asrc_wp_ns
  function automatic int asrc_cw_ns(input int g);   // select/address to end
    asrc_cw_ns = asrc_pick(g, 10, 12, 15);
  endfunction : asrc_cw_ns
  function automatic int asrc_dw_ns(input int g);   // data setup to write end
    asrc_dw_ns = asrc_pick(g, 7, 8, 9);
  endfunction : asrc_dw_ns
  function automatic int asrc_whz_ns(input int g);  // strobe to high-z
    asrc_whz_ns = asrc_pick(g, 5, 5, 8);
  endfunction : asrc_whz_ns
  function automatic int asrc_ohz_ns(input int g);  // gate high to high-z
    asrc_ohz_ns = asrc_pick(g, 5, 5, 7);
  endfunction : asrc_ohz_ns
  function automatic int asrc_chz_ns(input int g);  // deselect to high-z
    asrc_chz_ns = asrc_pick(g, 6, 7, 8);
  endfunction : asrc_chz_ns
  function automatic int asrc_oe_ns(input int g);   // gate to valid data
    asrc_oe_ns = asrc_pick(g, 6, 7, 8);
  endfunction : asrc_oe_ns
  localparam int ASRC_WR_NS = 0;  // write recovery

  localparam int ASRC_CNT_W = 4;
endpackage : asrc_pkg

`default_nettype wire

// [hdl/asrc_host.sv]
// asrc_host: host controller that runs one read or write on an async sram
// assumes req/ack user side on ref_clk; memory pins go straight to the part
`default_nettype none

module asrc_host #(
  parameter int GRADE = asrc_pkg::ASRC_GRADE_FAST
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire logic                           req_write,
  input  wire logic [asrc_pkg::ASRC_ADDR_W-1:0] req_addr,
  input  wire logic [asrc_pkg::ASRC_DATA_W-1:0] req_wdata,
  output logic                                rsp_valid,
  output logic [asrc_pkg::ASRC_DATA_W-1:0]    rsp_rdata,
  output logic [asrc_pkg::ASRC_ADDR_W-1:0]    mem_addr,
  output logic                                select_low_active_n,
  output logic                                select_high_active,
  output logic                                write_n,
  output logic                                out_gate_n,
  input  wire logic [asrc_pkg::ASRC_DATA_W-1:0] data_in,
  output logic [asrc_pkg::ASRC_DATA_W-1:0]    data_out,
  output logic                                data_oe
);
  // ---------------------------------------------------------------------
  // timing counts for the chosen grade
  // ---------------------------------------------------------------------
  typedef logic [asrc_pkg::ASRC_CNT_W-1:0] asrc_cnt_t;
  // address and selects settle, old drivers float before data goes out
  localparam int SETUP_C = asrc_pkg::asrc_cyc(
    asrc_pkg::asrc_chz_ns(GRADE) > asrc_pkg::asrc_ohz_ns(GRADE) ?
    asrc_pkg::asrc_chz_ns(GRADE) : asrc_pkg::asrc_ohz_ns(GRADE));
  localparam int WP_C = asrc_pkg::asrc_cyc(
    asrc_pkg::asrc_wp_ns(GRADE) > asrc_pkg::asrc_cw_ns(GRADE) ?
    asrc_pkg::asrc_wp_ns(GRADE) : asrc_pkg::asrc_cw_ns(GRADE));
  localparam int DW_C = asrc_pkg::asrc_cyc(asrc_pkg::asrc_dw_ns(GRADE));
  localparam int RC_C = asrc_pkg::asrc_cyc(asrc_pkg::asrc_rc_ns(GRADE));
  localparam int CW_C = asrc_pkg::asrc_cyc(asrc_pkg::asrc_cw_ns(GRADE));
  localparam int RD_MARGIN_C = 2;  // whole cycles of read window past access
  // the bus is caught a full cycle past access time, so a grade whose
  // access equals whole cycles never lands on the sampling edge
  localparam int RD_C = RC_C + RD_MARGIN_C;
  localparam asrc_cnt_t WP_CNT = asrc_cnt_t'(WP_C - 1);
  localparam asrc_cnt_t SU_CNT = asrc_cnt_t'(SETUP_C - 1);
  localparam asrc_cnt_t RD_CNT = asrc_cnt_t'(RD_C - 1);

  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_WSETUP, ASRC_WPULSE, ASRC_WEND, ASRC_READ, ASRC_RDONE
  } asrc_state_t;

  asrc_state_t                         state_q, state_d;
  asrc_cnt_t                           cnt_q, cnt_d;
  logic [asrc_pkg::ASRC_ADDR_W-1:0]    addr_q;
  logic [asrc_pkg::ASRC_DATA_W-1:0]    wdata_q;
  logic [asrc_pkg::ASRC_DATA_W-1:0]    rdata_q;
  logic [asrc_pkg::ASRC_DATA_W-1:0]    sync1_q, sync2_q;
  logic                                cnt_zero;
  logic                                take;
  logic                                sel_n_d, wr_n_d, gate_n_d, oe_d;
  logic                                sel_n_q, wr_n_q, gate_n_q, oe_q;

  // ---------------------------------------------------------------------
  // decoding
  // ---------------------------------------------------------------------
  assign cnt_zero  = (cnt_q == '0);
  assign req_ready = (state_q == ASRC_IDLE);
  assign take      = req_valid && req_ready;
  assign mem_addr  = addr_q;
  assign data_out  = wdata_q;
  // pin levels decoded from the next state and then registered, so a
  // state change can never glitch a strobe or a select on the async part
  // selects active across whole access, so strobe sits inside them
  assign sel_n_d  = (state_d == ASRC_IDLE) ||
                    (state_d == ASRC_RDONE);
  assign wr_n_d   = (state_d != ASRC_WPULSE);
  assign gate_n_d = (state_d != ASRC_READ);
  // data driven only once pulse starts, released the cycle it ends
  assign oe_d     = (state_d == ASRC_WPULSE);
  assign select_low_active_n = sel_n_q;
  assign select_high_active  = !sel_n_q;
  assign write_n    = wr_n_q;
  assign out_gate_n = gate_n_q;
  assign data_oe    = oe_q;
  assign rsp_rdata  = rdata_q;

  // next state and counter
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_zero ? cnt_q : cnt_q - asrc_cnt_t'(1);
    case (state_q)
      ASRC_IDLE:
      begin
        if (take)
        begin
          state_d = req_write ? ASRC_WSETUP : ASRC_READ;
          cnt_d   = req_write ? SU_CNT : RD_CNT;
        end
      end
      ASRC_WSETUP:
      begin
        if (cnt_zero)
        begin
          state_d = ASRC_WPULSE;
          cnt_d   = WP_CNT;
        end
      end
      ASRC_WPULSE: if (cnt_zero) state_d = ASRC_WEND;
      ASRC_WEND:   state_d = ASRC_IDLE;
      ASRC_READ:   if (cnt_zero) state_d = ASRC_RDONE;
      ASRC_RDONE:  state_d = ASRC_IDLE;
      default:     state_d = ASRC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ASRC_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // memory pin register; reset leaves the part deselected and quiet
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sel_n_q  <= 1'b1;
      wr_n_q   <= 1'b1;
      gate_n_q <= 1'b1;
      oe_q     <= 1'b0;
    end
    else
    begin
      sel_n_q  <= sel_n_d;
      wr_n_q   <= wr_n_d;
      gate_n_q <= gate_n_d;
      oe_q     <= oe_d;
    end
  end

  // request capture; address held through the whole access
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addr_q  <= '0;
      wdata_q <= '0;
    end
    else if (take)
    begin
      addr_q  <= req_addr;
      wdata_q <= req_wdata;
    end
  end

  // read data passes two flops before use
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      rdata_q   <= '0;
      rsp_valid <= 1'b0;
    end
    else
    begin
      sync1_q   <= data_in;
      sync2_q   <= sync1_q;
      rsp_valid <= (state_q == ASRC_RDONE);
      if (state_q == ASRC_RDONE)
        rdata_q <= sync2_q;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking asrc_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  write_overlap_a: assert property (
    !write_n |-> !select_low_active_n && select_high_active)
    else $error("strobe low outside select");
  pulse_width_a: assert property (
    $rose(write_n) |-> !$past(write_n, WP_C))
    else $error("write pulse too short");
  select_before_end_a: assert property (
    $rose(write_n) |-> !$past(select_low_active_n, CW_C) &&
    $past(select_high_active, CW_C))
    else $error("select not held before write end");
  data_float_a: assert property (
    data_oe |-> out_gate_n && !write_n)
    else $error("data driven while memory may drive");
  data_setup_a: assert property (
    $rose(write_n) |-> $past(data_oe, 1) && $past(data_oe, DW_C))
    else $error("write data not set up");
  addr_stable_a: assert property (
    !select_low_active_n && !$fell(select_low_active_n) |->
    $stable(mem_addr))
    else $error("address moved during access");
  write_cycle_a: assert property (
    $rose(write_n) |-> !select_low_active_n && $stable(mem_addr))
    else $error("write ended outside select");
  gate_read_only_a: assert property (
    !out_gate_n |-> write_n)
    else $error("gate low during write");
  read_done_a: assert property (
    $fell(out_gate_n) |-> ##[1:15] rsp_valid)
    else $error("read did not finish");

  write_seen_c: cover property ($rose(write_n) ##1 req_ready);
  read_seen_c:  cover property (rsp_valid);
  back_to_back_c: cover property (rsp_valid ##[1:3] $fell(write_n));
endmodule : asrc_host

`default_nettype wire

// [verif/asrc_sram_model.sv]
// asrc_sram_model: behavioural async sram facing asrc_host
// assumes host pins come straight in; resolves the shared data bus level
`default_nettype none

// ------------------------------------------------------------
// memory model
// ------------------------------------------------------------
module asrc_sram_model #(
  parameter int ACC_NS = 15
) (
  input  wire logic [asrc_pkg::ASRC_ADDR_W-1:0] mem_addr,
  input  wire logic                             select_low_active_n,
  input  wire logic                             select_high_active,
  input  wire logic                             write_n,
  input  wire logic                             out_gate_n,
  input  wire logic [asrc_pkg::ASRC_DATA_W-1:0] data_out,
  input  wire logic                             data_oe,
  output logic      [asrc_pkg::ASRC_DATA_W-1:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [0:131071];
  logic [7:0] rd_w;
  logic [7:0] bus_d;
  logic [7:0] last_q;
  // selection and drive decode
  wire logic sel = !select_low_active_n && select_high_active;
  wire logic wr  = sel && !write_n;
  wire logic drv = sel && write_n
                   && !out_gate_n;
  assign #(ACC_NS) rd_w = mem_q[mem_addr];
  // delayed copy so the byte is taken with zero hold at write end
  assign #1 bus_d = bus;
  always @(negedge wr) mem_q[mem_addr] = bus_d;
  // a released bus shows the inverse of the last driven value
  always @(data_out or rd_w or data_oe or drv)
    if (data_oe)
      last_q = data_out;
    else if (drv)
      last_q = rd_w;
  assign bus = data_oe ? data_out : drv ? rd_w : ~last_q;
endmodule : asrc_sram_model

`default_nettype wire

// [verif/testbench.sv]
// testbench: drives asrc_host against asrc_sram_model and checks timing
// assumes middle speed grade and a 100 MHz ref_clk
`default_nettype none

// ------------------------------------------------------------
// top
// ------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GRADE  = asrc_pkg::ASRC_GRADE_MID;
  localparam int CLK_NS = 10;
  localparam int WP_NS  = asrc_pkg::asrc_wp_ns(GRADE);
  localparam int CW_NS  = asrc_pkg::asrc_cw_ns(GRADE);
  localparam int DW_NS  = asrc_pkg::asrc_dw_ns(GRADE);
  localparam int ACC_NS = asrc_pkg::asrc_rc_ns(GRADE);
  logic        ref_clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic [16:0] req_addr = '0, mem_addr;
  logic [7:0]  req_wdata = '0, rsp_rdata, data_out, bus;
  logic        req_ready, rsp_valid, select_low_active_n, select_high_active;
  logic        write_n, out_gate_n, data_oe, sel, wl_q = 0;
  logic [16:0] ad_q = '0;
  int          failures = 0, num_checks = 0, bad = 0;
  int          wp_n = 0, cw_n = 0, dw_n = 0;
  int          last_wp = 0, last_cw = 0, last_dw = 0;

  asrc_host #(.GRADE(GRADE)) u_asrc_host (.ref_clk, .rst,
    .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
    .rsp_rdata, .mem_addr, .select_low_active_n, .select_high_active,
    .write_n, .out_gate_n, .data_in(bus), .data_out, .data_oe);
  asrc_sram_model #(.ACC_NS(ACC_NS)) u_asrc_sram_model (.mem_addr,
    .select_low_active_n, .select_high_active, .write_n, .out_gate_n,
    .data_out, .data_oe, .bus);

  always #5 ref_clk = ~ref_clk;

  // pin monitor: bus fights, address moves, pulse and overlap lengths;
  // sampled mid-cycle, where the registered pins have settled
  always @(negedge ref_clk)
  begin
    sel = !select_low_active_n && select_high_active;
    if (data_oe && !out_gate_n) bad++;
    if (!write_n && wl_q && mem_addr !== ad_q) bad++;
    if (!write_n)
      wp_n++;
    else if (wp_n != 0)
    begin
      last_wp = wp_n;
      last_cw = cw_n;
      last_dw = dw_n;
      wp_n = 0;
    end
    cw_n = sel ? cw_n + 1 : 0;
    dw_n = data_oe ? dw_n + 1 : 0;
    wl_q = !write_n;
    ad_q = mem_addr;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic access(input logic w, input logic [16:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
    #1 req_valid = 0;
    n = 0;
    while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("done", n < 50, 1);
  endtask : access

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    access(1, a, d);
    check("pulse", last_wp * CLK_NS >= WP_NS, 1);
    check("select", last_cw * CLK_NS >= CW_NS, 1);
    check("data", last_dw * CLK_NS >= DW_NS, 1);
  endtask : wr

  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    access(0, a, 8'h00);
    check("rdata", rsp_rdata, exp);
  endtask : rd

  task automatic t_reset;
    check("sel_n", select_low_active_n, 1);
    check("sel", select_high_active, 0);
    check("wr_n", write_n, 1);
    check("oe", data_oe, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rw;
    logic [16:0] at[3] = '{17'h00000, 17'h1ffff, 17'h0aaaa};
    logic [7:0]  dt[3] = '{8'ha5, 8'h5a, 8'h3c};
    foreach (at[i]) wr(at[i], dt[i]);
    foreach (at[i]) rd(at[i], dt[i]);
    $display("test write read done");
  endtask : t_rw

  task automatic t_b2b;
    access(1, 17'h00010, 8'hc3);
    wr(17'h00011, 8'h96);
    check("hold", rsp_rdata, 8'h3c);
    rd(17'h00010, 8'hc3);
    rd(17'h00011, 8'h96);
    rd(17'h00000, 8'ha5);
    // a write straight after a read, then read it back
    wr(17'h00012, 8'h69);
    rd(17'h00012, 8'h69);
    check("bus", bad, 0);
    $display("test back to back done");
  endtask : t_b2b

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1 t_reset();
    rst = 0;
    t_rw();
    t_b2b();
    tally_and_finish();
  end

  initial
  begin
    #20000 failures++;
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
